// file: hdl/sdpa_pkg.sv
// Function
// - low on sd_card_detect_n means card present, high means empty
// - insertion accepted only after detect stays low about 50 ms
// - removal reported at once, filtered detect drives the socket FSM
// - each flash socket FSM: empty, present unpowered, present powered
// - ms_card_detect_n gets the same debounce, removal and FSM
// - switch encoding chosen by switch_type_select, general control bit 10
// - after reset the first switch encoding is used
// - first-type VPP/VCORE code on D0,D1,D9 / D4,D5,D10 with D8
// - first-type VCC code on D3,D2 / D6,D7, D8 low gives Hi-Z
// - second-type VPP code, 10x gives 12 V, 11x gives Hi-Z
// - second type uses the same VCC encoding as the first
// - a 16 kHz tick times power-down and card interrogation
// - status-change pin pulls up for 16-bit, down for CardBus
// - binary audio reaches speaker_out only with speaker_out_enable set
// - pwm_audio_route steers CardBus PWM audio to pwm_audio_out
// - activity LEDs active high: socket A, socket B, either socket
// - each activity event holds its LED high 64 ms, else low
// - activity counts only with card present, powered, not in reset
// - 16-bit card is active while READY(IREQ) is low
// - CardBus card is active while CFRAME, IRDY or CREQ asserted
// - LEDs forced off in suspend, clock stop request, D1 or D2
// - new activity restarts the 64 ms count, keeping the LED on
package sdpa_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 16_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int DEB_MS = 50;
  localparam int DEB_TICKS = DEB_MS * OSC_HZ / 1000;
  localparam int LED_MS = 64;
  localparam int LED_CYC = LED_MS * (CLK_HZ / 1000);
  // ==========================================================
  // register map: index, byte address is four times index
  localparam int AW = 10;
  localparam logic [7:0] GEN_CTRL_IDX = 8'h86;
  localparam logic [7:0] CARD_CTRL_IDX = 8'h91;
  localparam logic [7:0] PWR_CTRL_IDX = 8'h80;
  localparam logic [7:0] STATUS_IDX = 8'h81;
  localparam int SW_TYPE_BIT = 10;
  localparam int SPK_EN_BIT = 1;
  localparam int PWM_RT_BIT = 2;
  // power control fields
  localparam int PC_SD_ON = 0;
  localparam int PC_MS_ON = 1;
  localparam int PC_VPPA = 2;
  localparam int PC_VCCA = 5;
  localparam int PC_VPPB = 7;
  localparam int PC_VCCB = 10;
  localparam int PC_SWITCH_SHUTDOWN_N = 12;
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  // vpp requests
  localparam logic [2:0] VPP_0V = 3'h0;
  localparam logic [2:0] VPP_3V3 = 3'h1;
  localparam logic [2:0] VPP_5V = 3'h2;
  localparam logic [2:0] VPP_12V = 3'h3;
  localparam logic [2:0] VPP_1V8 = 3'h4;
  localparam int SW_BITS = 11;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  typedef enum logic [1:0] {
    ST_EMPTY = 2'b00,
    ST_PRES_OFF = 2'b01,
    ST_PRES_ON = 2'b11
  } sdpa_fsm_e;
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_SHIFT = 2'b01,
    SR_LATCH = 2'b11
  } sdpa_ser_e;
  typedef struct packed {
    logic present;
    logic cardbus;
    logic powered;
    logic in_reset;
    logic ready_n;
    logic frame_act;
    logic irdy_act;
    logic creq_act;
    logic spkr;
    logic pwm;
  } sdpa_skt_s;
endpackage

// file: hdl/sdpa_top.sv
`timescale 1ns/1ps
module sdpa_top #(
  parameter int LED_CYCLES = sdpa_pkg::LED_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [sdpa_pkg::AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_sd_card_detect_n,
  input wire logic i_ms_card_detect_n,
  output logic [1:0] o_flash_present,
  output logic [1:0] o_flash_power,
  input wire sdpa_pkg::sdpa_skt_s i_skt_a,
  input wire sdpa_pkg::sdpa_skt_s i_skt_b,
  input wire logic i_suspend,
  input wire logic i_clkrun_stop,
  input wire logic [1:0] i_pwr_state,
  output logic o_sw_data,
  output logic o_sw_clk,
  output logic o_sw_latch,
  output logic [1:0] o_stschg_pullup,
  output logic o_speaker_out,
  output logic o_pwm_audio_out,
  output logic o_socket_a_activity_led,
  output logic o_socket_b_activity_led,
  output logic o_any_socket_activity_led
);
  import sdpa_pkg::*;

  localparam int DW = $clog2(DEB_TICKS + 1);
  localparam int LW = $clog2(LED_CYCLES + 1);
  localparam int OW = $clog2(OSC_DIV);

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  // unsupported voltages for a switch type fall back to Hi-Z
  function automatic logic [2:0] vpp_code(input logic [2:0] req, input logic typ);
    logic [2:0] c;
    c = typ ? 3'h6 : 3'h4;
    case (req)
      VPP_0V: c = 3'h0;
      VPP_3V3: c = 3'h2;
      VPP_5V: c = 3'h3;
      VPP_12V: c = typ ? 3'h4 : 3'h6;
      VPP_1V8: c = typ ? 3'h6 : 3'h7;
      default: c = typ ? 3'h6 : 3'h4;
    endcase
    vpp_code = c;
  endfunction

  // ==========================================================
  // registers
  logic sw_type_ff;
  logic [2:1] card_ctrl_ff;
  logic [PC_W-1:0] pwr_ctrl_ff;
  logic [31:0] status;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sw_type_ff <= 1'b0;
      card_ctrl_ff <= 2'h0;
      pwr_ctrl_ff <= PC_RST;
    end else if (i_wr) begin
      if (hit(i_addr, GEN_CTRL_IDX)) begin
        sw_type_ff <= i_wdata[SW_TYPE_BIT];
      end
      if (hit(i_addr, CARD_CTRL_IDX)) begin
        card_ctrl_ff <= i_wdata[PWM_RT_BIT:SPK_EN_BIT];
      end
      if (hit(i_addr, PWR_CTRL_IDX)) begin
        pwr_ctrl_ff <= i_wdata[PC_W-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      if (hit(i_addr, GEN_CTRL_IDX)) begin
        o_rdata <= 32'(sw_type_ff) << SW_TYPE_BIT;
      end else if (hit(i_addr, CARD_CTRL_IDX)) begin
        o_rdata <= {29'h0, card_ctrl_ff, 1'b0};
      end else if (hit(i_addr, PWR_CTRL_IDX)) begin
        o_rdata <= {19'h0, pwr_ctrl_ff};
      end else if (hit(i_addr, STATUS_IDX)) begin
        o_rdata <= status;
      end else begin
        o_rdata <= 32'h0;
      end
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // ==========================================================
  // 16 kHz housekeeping tick
  logic [OW-1:0] osc_cnt_ff;
  logic tick_ff;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      osc_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (osc_cnt_ff == OW'(OSC_DIV - 1));
      osc_cnt_ff <= (osc_cnt_ff == OW'(OSC_DIV - 1)) ? '0 : osc_cnt_ff + 1'b1;
    end
  end

  // ==========================================================
  // flash socket detection and power
  logic [1:0] det_n;
  logic [1:0] pwr_req;
  logic [1:0] deb_done;
  logic [DW-1:0] deb_cnt_ff [2];
  sdpa_fsm_e st_ff [2];
  sdpa_fsm_e nxt_st [2];

  assign det_n = {i_ms_card_detect_n, i_sd_card_detect_n};
  assign pwr_req = {pwr_ctrl_ff[PC_MS_ON], pwr_ctrl_ff[PC_SD_ON]};

  for (genvar g = 0; g < 2; g++) begin : g_flash
    assign deb_done[g] = (deb_cnt_ff[g] == DW'(DEB_TICKS));

    // any high sample restarts the window, so glitches never insert
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n || det_n[g]) begin
        deb_cnt_ff[g] <= '0;
      end else if (tick_ff && !deb_done[g]) begin
        deb_cnt_ff[g] <= deb_cnt_ff[g] + 1'b1;
      end
    end

    always_comb begin
      nxt_st[g] = st_ff[g];
      case (st_ff[g])
        ST_EMPTY: begin
          // the count still reads done in the cycle a glitch clears it
          if (deb_done[g] && !det_n[g]) begin
            nxt_st[g] = ST_PRES_OFF;
          end
        end
        ST_PRES_OFF: begin
          if (det_n[g]) begin
            nxt_st[g] = ST_EMPTY;
          end else if (tick_ff && pwr_req[g]) begin
            nxt_st[g] = ST_PRES_ON;
          end
        end
        ST_PRES_ON: begin
          if (det_n[g]) begin
            nxt_st[g] = ST_EMPTY;
          end else if (tick_ff && !pwr_req[g]) begin
            nxt_st[g] = ST_PRES_OFF;
          end
        end
        default: nxt_st[g] = ST_EMPTY;
      endcase
    end

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        st_ff[g] <= ST_EMPTY;
        o_flash_present[g] <= 1'b0;
        o_flash_power[g] <= 1'b0;
      end else begin
        st_ff[g] <= nxt_st[g];
        o_flash_present[g] <= (nxt_st[g] != ST_EMPTY);
        o_flash_power[g] <= (nxt_st[g] == ST_PRES_ON);
      end
    end
  end

  // ==========================================================
  // power switch word and serial shifter
  logic [SW_BITS-1:0] sw_word;
  logic [SW_BITS-1:0] sent_ff;
  logic [SW_BITS-1:0] shreg_ff;
  logic [3:0] bit_cnt_ff;
  logic phase_ff;
  sdpa_ser_e ser_ff;

  always_comb begin
    logic [2:0] va;
    logic [2:0] vb;
    va = vpp_code(pwr_ctrl_ff[PC_VPPA +: 3], sw_type_ff);
    vb = vpp_code(pwr_ctrl_ff[PC_VPPB +: 3], sw_type_ff);
    sw_word = '0;
    sw_word[0] = va[2];
    sw_word[1] = va[1];
    sw_word[9] = va[0];
    sw_word[4] = vb[2];
    sw_word[5] = vb[1];
    sw_word[10] = vb[0];
    sw_word[3] = pwr_ctrl_ff[PC_VCCA + 1];
    sw_word[2] = pwr_ctrl_ff[PC_VCCA];
    sw_word[6] = pwr_ctrl_ff[PC_VCCB + 1];
    sw_word[7] = pwr_ctrl_ff[PC_VCCB];
    sw_word[8] = pwr_ctrl_ff[PC_SWITCH_SHUTDOWN_N];
  end

  // D0 first, one bit per two ticks; the word is resent whenever it changes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ser_ff <= SR_IDLE;
      sent_ff <= '0;
      shreg_ff <= '0;
      bit_cnt_ff <= 4'h0;
      phase_ff <= 1'b0;
      o_sw_data <= 1'b0;
      o_sw_clk <= 1'b0;
      o_sw_latch <= 1'b0;
    end else if (tick_ff) begin
      case (ser_ff)
        SR_IDLE: begin
          if (sw_word != sent_ff) begin
            sent_ff <= sw_word;
            shreg_ff <= sw_word;
            bit_cnt_ff <= 4'h0;
            phase_ff <= 1'b0;
            ser_ff <= SR_SHIFT;
          end
        end
        SR_SHIFT: begin
          phase_ff <= !phase_ff;
          if (!phase_ff) begin
            o_sw_data <= shreg_ff[0];
            o_sw_clk <= 1'b0;
          end else begin
            o_sw_clk <= 1'b1;
            shreg_ff <= shreg_ff >> 1;
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (bit_cnt_ff == 4'(SW_BITS - 1)) begin
              ser_ff <= SR_LATCH;
            end
          end
        end
        SR_LATCH: begin
          o_sw_clk <= 1'b0;
          o_sw_latch <= !o_sw_latch;
          if (o_sw_latch) begin
            ser_ff <= SR_IDLE;
          end
        end
        default: ser_ff <= SR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pull select and audio
  sdpa_skt_s skt [2];
  assign skt[0] = i_skt_a;
  assign skt[1] = i_skt_b;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_stschg_pullup <= 2'h3;
      o_speaker_out <= 1'b0;
      o_pwm_audio_out <= 1'b0;
    end else begin
      o_stschg_pullup[0] <= !(skt[0].present && skt[0].cardbus);
      o_stschg_pullup[1] <= !(skt[1].present && skt[1].cardbus);
      o_speaker_out <= card_ctrl_ff[SPK_EN_BIT] && (skt[0].spkr || skt[1].spkr);
      o_pwm_audio_out <= card_ctrl_ff[PWM_RT_BIT] &&
        ((skt[0].cardbus && skt[0].pwm) || (skt[1].cardbus && skt[1].pwm));
    end
  end

  // ==========================================================
  // activity LEDs
  logic [1:0] act;
  logic [1:0] nxt_led;
  logic [1:0] led_ff;
  logic [LW-1:0] led_cnt_ff [2];
  logic force_off;

  // a stopped bus clock must not leave an LED looking stuck on
  assign force_off = i_suspend || i_clkrun_stop || i_pwr_state == PS_D1 || i_pwr_state == PS_D2;

  for (genvar g = 0; g < 2; g++) begin : g_led
    assign act[g] = skt[g].present && skt[g].powered && !skt[g].in_reset &&
      (skt[g].cardbus ? (skt[g].frame_act || skt[g].irdy_act || skt[g].creq_act)
                      : !skt[g].ready_n);
    assign nxt_led[g] = !force_off && (act[g] || led_cnt_ff[g] > LW'(1));

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n || force_off) begin
        led_cnt_ff[g] <= '0;
      end else if (act[g]) begin
        led_cnt_ff[g] <= LW'(LED_CYCLES);
      end else if (led_cnt_ff[g] != '0) begin
        led_cnt_ff[g] <= led_cnt_ff[g] - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      led_ff <= 2'h0;
      o_any_socket_activity_led <= 1'b0;
    end else begin
      led_ff <= nxt_led;
      o_any_socket_activity_led <= |nxt_led;
    end
  end

  assign o_socket_a_activity_led = led_ff[0];
  assign o_socket_b_activity_led = led_ff[1];
  assign status = {24'h0, ser_ff != SR_IDLE, led_ff, deb_done, 1'b0, o_flash_power};

  // ==========================================================
  // checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_type_after_reset: assert property (disable iff (1'b0) !i_rst_n |=> !sw_type_ff)
    else $error("switch type not first after reset");
  a_removal_at_once: assert property ($rose(i_sd_card_detect_n) |=> st_ff[0] == ST_EMPTY)
    else $error("removal not immediate");
  a_insert_needs_deb: assert property (st_ff[1] == ST_EMPTY ##1 st_ff[1] == ST_PRES_OFF
    |-> $past(deb_done[1]) && $past(!i_ms_card_detect_n))
    else $error("insertion without debounce");
  a_led_force_off: assert property (force_off |=> !o_socket_a_activity_led && !o_any_socket_activity_led)
    else $error("led not forced off");
  a_led_on_activity: assert property (act[1] && !force_off |=> o_socket_b_activity_led)
    else $error("led missing after activity");
  a_led_hold: assert property (act[0] && !force_off ##1 !force_off [*3] |=> o_socket_a_activity_led)
    else $error("led dropped early");
  a_any_led_or: assert property (o_any_socket_activity_led == (led_ff[0] || led_ff[1]))
    else $error("any led mismatch");
  a_act_needs_power: assert property (!skt[0].powered || skt[0].in_reset |-> !act[0])
    else $error("activity without power");
  a_spk_gate: assert property (!card_ctrl_ff[SPK_EN_BIT] |=> !o_speaker_out)
    else $error("speaker not gated");
  a_pwm_gate: assert property (!card_ctrl_ff[PWM_RT_BIT] |=> !o_pwm_audio_out)
    else $error("pwm not gated");

  c_insert: cover property (st_ff[0] == ST_EMPTY ##1 st_ff[0] == ST_PRES_OFF);
  c_power_on: cover property (st_ff[1] == ST_PRES_ON);
  c_latch: cover property (o_sw_latch);
  c_led_any: cover property (o_any_socket_activity_led);
endmodule

// file: testbench/sdpa_switch_model.sv
`timescale 1ns/1ps
// ==========================================================
// power switch: shifts on rising clock, takes word on rising latch
module sdpa_switch_model (
  input wire logic i_mclk,
  input wire logic i_sw_data,
  input wire logic i_sw_clk,
  input wire logic i_sw_latch,
  output logic [10:0] o_word,
  output int o_n_latch
);
  logic [10:0] sr_ff;
  logic clk_ff;
  logic lat_ff;
  initial begin
    sr_ff = '0;
    clk_ff = 1'b0;
    lat_ff = 1'b0;
    o_word = '0;
    o_n_latch = 0;
  end
  always @(posedge i_mclk) begin
    clk_ff <= i_sw_clk;
    lat_ff <= i_sw_latch;
    // first bit shifted in ends at the bottom
    if (i_sw_clk && !clk_ff) sr_ff <= {i_sw_data, sr_ff[10:1]};
    if (i_sw_latch && !lat_ff) begin
      o_word <= sr_ff;
      o_n_latch <= o_n_latch + 1;
    end
  end
endmodule

// file: testbench/sdpa_top_tb.sv
`timescale 1ns/1ps
module sdpa_top_tb;
  import sdpa_pkg::*;
  localparam int LEDC = 20;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [AW-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_sd_n = 1'b1;
  logic i_ms_n = 1'b1;
  logic [1:0] o_pres, o_pwr, o_pull, i_pst = 2'h0;
  sdpa_skt_s i_skt_a = '0;
  sdpa_skt_s i_skt_b = '0;
  logic i_susp = 1'b0;
  logic i_stop = 1'b0;
  logic sw_d, sw_c, sw_l, spk, pwm, la, lb, lany;
  logic [10:0] sw_word;
  logic [31:0] d;
  int sw_n, n_mismatch, n_compared;
  logic [15:0] lfsr = 16'h0027;
  always #50 i_mclk = ~i_mclk;
  sdpa_top #(.LED_CYCLES(LEDC)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sd_card_detect_n(i_sd_n), .i_ms_card_detect_n(i_ms_n),
    .o_flash_present(o_pres), .o_flash_power(o_pwr), .i_skt_a(i_skt_a), .i_skt_b(i_skt_b),
    .i_suspend(i_susp), .i_clkrun_stop(i_stop), .i_pwr_state(i_pst), .o_sw_data(sw_d), .o_sw_clk(sw_c),
    .o_sw_latch(sw_l), .o_stschg_pullup(o_pull), .o_speaker_out(spk), .o_pwm_audio_out(pwm),
    .o_socket_a_activity_led(la), .o_socket_b_activity_led(lb), .o_any_socket_activity_led(lany));
  sdpa_switch_model sw (.i_mclk(i_mclk), .i_sw_data(sw_d), .i_sw_clk(sw_c), .i_sw_latch(sw_l),
    .o_word(sw_word), .o_n_latch(sw_n));
  // ==========================================================
  // reference model
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function logic [2:0] vpp(logic t, logic [2:0] r);
    case (r)
      VPP_0V: return 3'h0;
      VPP_3V3: return 3'h2;
      VPP_5V: return 3'h3;
      VPP_12V: return t ? 3'h4 : 3'h6;
      VPP_1V8: return t ? 3'h6 : 3'h7;
      default: return t ? 3'h6 : 3'h4;
    endcase
  endfunction
  function logic [10:0] swword(logic t, logic [12:0] p);
    logic [10:0] w;
    w = '0;
    {w[0], w[1], w[9]} = vpp(t, p[4:2]);
    {w[4], w[5], w[10]} = vpp(t, p[9:7]);
    {w[3], w[2]} = p[6:5];
    {w[6], w[7]} = p[11:10];
    w[8] = p[12];
    return w;
  endfunction
  // ==========================================================
  // bus and check tasks
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task wr(logic [9:0] a, logic [31:0] v);
    @(posedge i_mclk) begin
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
    end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask
  task rd(logic [9:0] a, output logic [31:0] v);
    @(posedge i_mclk) begin
      i_addr <= a;
      i_rd <= 1'b1;
    end
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task pulse(logic b, sdpa_skt_s on, sdpa_skt_s off);
    @(posedge i_mclk) if (b) i_skt_b <= on; else i_skt_a <= on;
    @(posedge i_mclk) if (b) i_skt_b <= off; else i_skt_a <= off;
    #1;
  endtask
  task hold(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task wait_latch(int n0);
    int i;
    i = 0;
    while (sw_n == n0 && i < 20000) begin
      @(posedge i_mclk);
      i++;
    end
    hold(1);
  endtask
  task tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1 chk("outs", {o_pres, o_pwr, sw_d, sw_c, sw_l, spk, pwm, la, lb, lany}, 0);
    chk("pull", o_pull, 2'h3);
    rd(10'h218, d);
    chk("genctrl", d, 0);
    wr(10'h204, 32'hFFFFFFFF);
    rd(10'h204, d);
    chk("status", d, 0);
    wr(10'h3FC, rnd());
    rd(10'h3FC, d);
    chk("unmapped", d, 0);
    // a short low on detect must not count as an insertion
    @(posedge i_mclk) {i_sd_n, i_ms_n} <= 2'b00;
    hold(1000);
    @(posedge i_mclk) {i_sd_n, i_ms_n} <= 2'b11;
    hold(3);
    chk("present", {o_pres, o_pwr}, 0);
    // audio routing, random control values
    repeat (4) begin
      d = {16'h0, rnd()};
      wr(10'h244, d);
      rd(10'h244, i_wdata);
      chk("cardctrl", i_wdata, {29'h0, d[2:1], 1'b0});
      @(posedge i_mclk) i_skt_a <= 10'b1010_1000_10;
      hold(3);
      chk("speaker", spk, d[1]);
      @(posedge i_mclk) i_skt_a <= 10'b1110_1000_01;
      hold(3);
      chk("pwm", pwm, d[2]);
    end
    // activity leds
    pulse(0, 10'b1010_0000_00, 10'b1010_1000_00);
    chk("led_a", {la, lany}, 2'h3);
    hold(LEDC - 3);
    chk("led_a", la, 1);
    hold(5);
    chk("led_a", {la, lany}, 0);
    pulse(0, 10'b1010_0000_00, 10'b1010_1000_00);
    hold(10);
    pulse(0, 10'b1010_0000_00, 10'b1010_1000_00);
    hold(LEDC - 3);
    chk("led_a", la, 1);
    hold(5);
    chk("led_a", la, 0);
    for (int k = 0; k < 3; k++) begin
      pulse(0, 10'b1110_1000_00 | (10'h010 >> k), 10'b1110_1000_00);
      chk("led_a", la, 1);
      chk("pull", o_pull[0], 0);
      hold(LEDC + 3);
      chk("led_a", la, 0);
    end
    pulse(1, 10'b1110_1100_00, 10'b1110_1000_00);
    chk("led_b", {la, lb, lany}, 3'h3);
    hold(LEDC + 3);
    pulse(0, 10'b1011_0000_00, 10'b1010_1000_00);
    chk("led_rst", la, 0);
    pulse(0, 10'b1000_0000_00, 10'b1010_1000_00);
    chk("led_unpwr", la, 0);
    for (int k = 0; k < 4; k++) begin
      pulse(0, 10'b1010_0000_00, 10'b1010_1000_00);
      @(posedge i_mclk) begin
        i_susp <= (k == 0);
        i_stop <= (k == 1);
        i_pst <= (k == 2) ? PS_D1 : (k == 3) ? PS_D2 : 2'h0;
      end
      hold(1);
      @(posedge i_mclk) {i_susp, i_stop, i_pst} <= 4'h0;
      #1 chk("led_off", {la, lb, lany}, 0);
      hold(2);
      chk("led_off", la, 0);
    end
    // switch words under both encodings
    wr(10'h200, 32'h19B0);
    wait_latch(0);
    chk("sw_word0", sw_word, swword(1'b0, 13'h19B0));
    wr(10'h218, 32'h400);
    wait_latch(1);
    chk("sw_word1", sw_word, swword(1'b1, 13'h19B0));
    tally_and_finish();
  end
endmodule
